/* hdl/elc_pkg.sv */
package elc_pkg;

	// Number of external links handled by this block.
	localparam int NUM_LINKS = 8;

	// Register indices; the byte address is four times the index.
	localparam logic [7:0] CFG_BASE_IDX = 8'h80;
	localparam logic [7:0] STATIC_BASE_IDX = 8'hA0;
	localparam logic [11:0] CFG_BASE_ADDR = {2'b00, CFG_BASE_IDX, 2'b00};
	localparam logic [11:0] STATIC_BASE_ADDR = {2'b00, STATIC_BASE_IDX, 2'b00};

	// Field positions of the link configuration register.
	localparam int CFG_EN_BIT = 31;
	localparam int CFG_WIDE_BIT = 30;
	localparam int CFG_ERR_BIT = 27;
	localparam int CFG_CRED_OUT_BIT = 26;
	localparam int CFG_CRED_IN_BIT = 25;
	localparam int CFG_INIT_BIT = 24;
	localparam int CFG_RXRST_BIT = 23;
	localparam int CFG_TRANS_MSB = 21;
	localparam int CFG_TRANS_LSB = 11;
	localparam int CFG_TOKEN_MSB = 10;
	localparam int CFG_TOKEN_LSB = 0;

	// Field positions of the static forwarding register.
	localparam int STATIC_EN_BIT = 31;
	localparam int STATIC_CHAN_MSB = 4;

	// Reset values of both registers.
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] STATIC_RESET = 32'h0000_0000;

	// Control token payloads used for the credit handshake.
	localparam logic [7:0] GREETING_DATA = 8'h01;
	localparam logic [7:0] CREDIT_DATA = 8'h02;

	// Symbols per token in the two line forms.
	localparam logic [3:0] SYMS_NARROW = 4'hA;
	localparam logic [3:0] SYMS_WIDE = 4'h5;

	// One token on the link: a control flag and eight data bits.
	typedef struct packed {
		logic ctrl;
		logic [7:0] data;
	} elc_token_t;

	// Transmitter timing and width settings.
	typedef struct packed {
		logic five_wire;
		logic [10:0] trans_gap;
		logic [10:0] token_gap;
	} elc_cfg_t;

	// A received token handed to the switch, with its forwarding decision.
	typedef struct packed {
		logic valid;
		logic static_fwd;
		logic [4:0] chanend;
		elc_token_t token;
	} elc_rx_t;

endpackage

/* hdl/elc_link_tx.sv */
`timescale 1ns/100ps
module elc_link_tx (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire elc_pkg::elc_cfg_t cfg,
	input wire logic tok_valid,
	input wire elc_pkg::elc_token_t tok,
	output logic tok_ready,
	output logic [4:0] wires
);
	// Serialiser states: waiting for a token, sending symbols, token gap.
	typedef enum logic [1:0] {ELC_TX_IDLE, ELC_TX_SEND, ELC_TX_GAP} elc_tx_state_t;

	elc_tx_state_t state;
	// Bits still to send, least significant first.
	logic [9:0] shift;
	// Symbols sent so far in this token.
	logic [3:0] sym_count;
	// Clocks left before the next transition or token.
	logic [10:0] gap_count;
	logic [3:0] sym_total;

	// Two-wire form carries one bit per transition, five-wire two.
	assign sym_total = cfg.five_wire ? elc_pkg::SYMS_WIDE : elc_pkg::SYMS_NARROW;
	assign tok_ready = enable && (state == ELC_TX_IDLE);

	// Shift out one symbol each time the spacing counter expires.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= ELC_TX_IDLE;
			shift <= 10'h000;
			sym_count <= 4'h0;
			gap_count <= 11'h000;
			wires <= 5'h00;
		end
		else if (!enable)
		begin
			// A disabled link leaves its wires still.
			state <= ELC_TX_IDLE;
			sym_count <= 4'h0;
			gap_count <= 11'h000;
		end
		else
		begin
			case (state)
				ELC_TX_IDLE:
				begin
					if (tok_valid)
					begin
						shift <= {tok.ctrl, tok.data, 1'b0};
						sym_count <= 4'h0;
						gap_count <= 11'h000;
						state <= ELC_TX_SEND;
					end
				end
				ELC_TX_SEND:
				begin
					if (gap_count != 11'h000)
					begin
						gap_count <= gap_count - 11'h001;
					end
					else
					begin
						// One wire toggles per symbol; its index is the data.
						if (cfg.five_wire)
						begin
							wires[shift[1:0]] <= ~wires[shift[1:0]];
							shift <= {2'b00, shift[9:2]};
						end
						else
						begin
							wires[shift[0]] <= ~wires[shift[0]];
							shift <= {1'b0, shift[9:1]};
						end
						sym_count <= sym_count + 4'h1;
						if (sym_count == sym_total - 4'h1)
						begin
							gap_count <= cfg.token_gap;
							state <= ELC_TX_GAP;
						end
						else
						begin
							gap_count <= cfg.trans_gap;
						end
					end
				end
				ELC_TX_GAP:
				begin
					if (gap_count == 11'h000)
					begin
						state <= ELC_TX_IDLE;
					end
					else
					begin
						gap_count <= gap_count - 11'h001;
					end
				end
				default:
				begin
					state <= ELC_TX_IDLE;
				end
			endcase
		end
	end

endmodule // elc_link_tx

/* hdl/elc_link_rx.sv */
`timescale 1ns/100ps
module elc_link_rx (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic five_wire,
	input wire logic restart,
	input wire logic [4:0] wires_sync,
	output logic tok_valid,
	output elc_pkg::elc_token_t tok,
	output logic illegal
);
	// Line levels seen one clock earlier.
	logic [4:0] prev;
	// Partly assembled token and its symbol count.
	logic [9:0] shift;
	logic [3:0] sym_count;
	logic [4:0] toggles;
	logic legal;
	logic [9:0] next_shift;
	logic [3:0] sym_total;

	assign toggles = wires_sync ^ prev;
	assign sym_total = five_wire ? elc_pkg::SYMS_WIDE : elc_pkg::SYMS_NARROW;

	// A symbol is exactly one toggling wire within the form's wire set.
	always_comb
	begin
		legal = $onehot(toggles) && !toggles[4] && (five_wire || toggles[3:2] == 2'b00);
		if (five_wire)
		begin
			next_shift = {toggles[3] | toggles[2], toggles[3] | toggles[1], shift[9:2]};
		end
		else
		begin
			next_shift = {toggles[1], shift[9:1]};
		end
	end

	// Assemble symbols into tokens and flag bad encodings.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prev <= 5'h00;
			shift <= 10'h000;
			sym_count <= 4'h0;
			tok_valid <= 1'b0;
			tok <= '0;
			illegal <= 1'b0;
		end
		else
		begin
			// Levels are always tracked so a restart begins on a fresh edge.
			prev <= wires_sync;
			tok_valid <= 1'b0;
			illegal <= 1'b0;
			if (!enable || restart)
			begin
				sym_count <= 4'h0;
			end
			else if (toggles != 5'h00)
			begin
				if (!legal)
				begin
					illegal <= 1'b1;
					sym_count <= 4'h0;
				end
				else if (sym_count == sym_total - 4'h1)
				begin
					tok_valid <= 1'b1;
					tok <= {next_shift[9], next_shift[8:1]};
					sym_count <= 4'h0;
				end
				else
				begin
					shift <= next_shift;
					sym_count <= sym_count + 4'h1;
				end
			end
		end
	end

endmodule // elc_link_rx

/* hdl/elc_link_control.sv */
`timescale 1ns/100ps
module elc_link_control (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] pin_mux_to_link,
	output logic [7:0][4:0] link_tx_wire,
	input wire logic [7:0][4:0] link_rx_wire,
	input wire logic [7:0] user_tx_valid,
	input wire elc_pkg::elc_token_t [7:0] user_tx_token,
	output logic [7:0] user_tx_ready,
	output elc_pkg::elc_rx_t [7:0] switch_rx,
	input wire logic [7:0] switch_rx_ready
);
	// Slot i of each register bank serves link number i; in lettered
	// terms slots 0 to 7 are links C, D, B, A, G, H, E and F.

	// Configuration fields, one entry per link.
	logic [7:0] link_en;
	logic [7:0] five_wire;
	logic [7:0][10:0] trans_gap;
	logic [7:0][10:0] token_gap;
	// Sticky error flags and credit state.
	logic [7:0] link_err;
	logic [7:0] cred_out;
	logic [7:0] cred_in;
	// Control tokens still waiting for the transmitter.
	logic [7:0] greet_pend;
	logic [7:0] credit_pend;
	// One-clock receiver restart strobes.
	logic [7:0] rx_restart;
	// Static forwarding settings.
	logic [7:0] static_en;
	logic [7:0][4:0] static_chan;
	// Error bits that the pending read has captured.
	logic [7:0] err_seen;
	// Receive pins: first and second synchroniser stages.
	logic [7:0][4:0] rx_meta;
	logic [7:0][4:0] rx_sync;
	// Transmitter request and handshake per link.
	logic [7:0] tx_valid;
	logic [7:0] tx_ready;
	elc_pkg::elc_token_t [7:0] tx_token;
	elc_pkg::elc_cfg_t [7:0] tx_cfg;
	// Receiver outputs per link.
	logic [7:0] rx_tok_valid;
	logic [7:0] rx_illegal;
	elc_pkg::elc_token_t [7:0] rx_tok;
	// Decoded bus strobes.
	logic setup_rd;
	logic access;
	logic wr_cfg;
	logic wr_static;
	logic rd_cfg;
	logic [2:0] slot;

	// True when the address falls in a bank of eight aligned words.
	function automatic logic bank_hit(input logic [11:0] addr, input logic [11:0] base);
		bank_hit = (addr[11:5] == base[11:5]) && (addr[1:0] == 2'b00);
	endfunction

	// Read image of one link's configuration word.
	function automatic logic [31:0] cfg_word(input int i);
		logic [31:0] w;
		w = elc_pkg::CFG_RESET;
		w[elc_pkg::CFG_EN_BIT] = link_en[i];
		w[elc_pkg::CFG_WIDE_BIT] = five_wire[i];
		w[elc_pkg::CFG_ERR_BIT] = link_err[i];
		w[elc_pkg::CFG_CRED_OUT_BIT] = cred_out[i];
		w[elc_pkg::CFG_CRED_IN_BIT] = cred_in[i];
		w[elc_pkg::CFG_TRANS_MSB:elc_pkg::CFG_TRANS_LSB] = trans_gap[i];
		w[elc_pkg::CFG_TOKEN_MSB:elc_pkg::CFG_TOKEN_LSB] = token_gap[i];
		cfg_word = w;
	endfunction

	// The slave never inserts wait states; every access takes two clocks.
	assign pready = 1'b1;
	assign slot = paddr[4:2];
	assign setup_rd = psel && !penable && !pwrite;
	assign access = psel && penable;
	assign pslverr = access && !bank_hit(paddr, elc_pkg::CFG_BASE_ADDR)
		&& !bank_hit(paddr, elc_pkg::STATIC_BASE_ADDR);
	assign wr_cfg = access && pwrite && bank_hit(paddr, elc_pkg::CFG_BASE_ADDR);
	assign wr_static = access && pwrite && bank_hit(paddr, elc_pkg::STATIC_BASE_ADDR);
	assign rd_cfg = access && !pwrite && bank_hit(paddr, elc_pkg::CFG_BASE_ADDR);

	// Enabled links claim their shared pins.
	assign pin_mux_to_link = link_en;

	// Read data is captured in the setup cycle so it comes from flops.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prdata <= 32'h0000_0000;
			err_seen <= 8'h00;
		end
		else if (setup_rd)
		begin
			prdata <= 32'h0000_0000;
			err_seen <= 8'h00;
			if (bank_hit(paddr, elc_pkg::CFG_BASE_ADDR))
			begin
				prdata <= cfg_word(int'(slot));
				err_seen[slot] <= link_err[slot];
			end
			else if (bank_hit(paddr, elc_pkg::STATIC_BASE_ADDR))
			begin
				prdata[elc_pkg::STATIC_EN_BIT] <= static_en[slot];
				prdata[elc_pkg::STATIC_CHAN_MSB:0] <= static_chan[slot];
			end
		end
	end

	// Writable configuration fields.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link_en <= 8'h00;
			five_wire <= 8'h00;
			trans_gap <= '0;
			token_gap <= '0;
			static_en <= 8'h00;
			static_chan <= '0;
		end
		else
		begin
			if (wr_cfg)
			begin
				link_en[slot] <= pwdata[elc_pkg::CFG_EN_BIT];
				five_wire[slot] <= pwdata[elc_pkg::CFG_WIDE_BIT];
				trans_gap[slot] <= pwdata[elc_pkg::CFG_TRANS_MSB:elc_pkg::CFG_TRANS_LSB];
				token_gap[slot] <= pwdata[elc_pkg::CFG_TOKEN_MSB:elc_pkg::CFG_TOKEN_LSB];
			end
			if (wr_static)
			begin
				static_en[slot] <= pwdata[elc_pkg::STATIC_EN_BIT];
				static_chan[slot] <= pwdata[elc_pkg::STATIC_CHAN_MSB:0];
			end
		end
	end

	// Receiver restart strobe lasts one clock, so the bit reads back zero.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_restart <= 8'h00;
		end
		else
		begin
			rx_restart <= 8'h00;
			if (wr_cfg && pwdata[elc_pkg::CFG_RXRST_BIT])
			begin
				rx_restart[slot] <= 1'b1;
			end
		end
	end

	// Two-stage synchroniser on every receive wire.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_meta <= '0;
			rx_sync <= '0;
		end
		else
		begin
			rx_meta <= link_rx_wire;
			rx_sync <= rx_meta;
		end
	end

	// Transmit arbitration: greeting first, then credit, then user data.
	// User data waits for credit, which is how the peer throttles us.
	always_comb
	begin
		for (int i = 0; i < elc_pkg::NUM_LINKS; i++)
		begin
			tx_cfg[i] = {five_wire[i], trans_gap[i], token_gap[i]};
			user_tx_ready[i] = 1'b0;
			if (greet_pend[i])
			begin
				tx_valid[i] = 1'b1;
				tx_token[i] = {1'b1, elc_pkg::GREETING_DATA};
			end
			else if (credit_pend[i])
			begin
				tx_valid[i] = 1'b1;
				tx_token[i] = {1'b1, elc_pkg::CREDIT_DATA};
			end
			else
			begin
				tx_valid[i] = user_tx_valid[i] && cred_in[i];
				tx_token[i] = user_tx_token[i];
				user_tx_ready[i] = tx_ready[i] && cred_in[i];
			end
		end
	end

	// Credit handshake state per link.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			greet_pend <= 8'h00;
			credit_pend <= 8'h00;
			cred_in <= 8'h00;
			cred_out <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < elc_pkg::NUM_LINKS; i++)
			begin
				if (!link_en[i] && !(wr_cfg && slot == 3'(i) && pwdata[elc_pkg::CFG_EN_BIT]))
				begin
					// A disabled link forgets its handshake; an enabling write keeps its init.
					greet_pend[i] <= 1'b0;
					credit_pend[i] <= 1'b0;
					cred_in[i] <= 1'b0;
					cred_out[i] <= 1'b0;
				end
				else
				begin
					// A sent greeting or credit token retires its request.
					if (greet_pend[i] && tx_ready[i])
					begin
						greet_pend[i] <= 1'b0;
					end
					else if (credit_pend[i] && tx_ready[i])
					begin
						credit_pend[i] <= 1'b0;
						cred_out[i] <= 1'b1;
					end
					// Peer greeting: answer with credit, as any link end does.
					if (rx_tok_valid[i] && rx_tok[i].ctrl
						&& rx_tok[i].data == elc_pkg::GREETING_DATA)
					begin
						credit_pend[i] <= 1'b1;
					end
					// Peer credit lets us transmit; init drops it again.
					if (wr_cfg && slot == 3'(i) && pwdata[elc_pkg::CFG_INIT_BIT])
					begin
						cred_in[i] <= 1'b0;
						greet_pend[i] <= 1'b1;
					end
					else if (rx_tok_valid[i] && rx_tok[i].ctrl
						&& rx_tok[i].data == elc_pkg::CREDIT_DATA)
					begin
						cred_in[i] <= 1'b1;
					end
					// Credit granted earlier is void once our receiver restarts.
					if (rx_restart[i])
					begin
						cred_out[i] <= 1'b0;
					end
				end
			end
		end
	end

	// One-entry receive buffer per link, with static forwarding decision.
	// Control tokens for the handshake are consumed here and never buffered.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			switch_rx <= '0;
		end
		else
		begin
			for (int i = 0; i < elc_pkg::NUM_LINKS; i++)
			begin
				if (switch_rx[i].valid && switch_rx_ready[i])
				begin
					switch_rx[i].valid <= 1'b0;
				end
				if (rx_tok_valid[i] && !(rx_tok[i].ctrl
					&& (rx_tok[i].data == elc_pkg::GREETING_DATA
					|| rx_tok[i].data == elc_pkg::CREDIT_DATA))
					&& (!switch_rx[i].valid || switch_rx_ready[i]))
				begin
					switch_rx[i].valid <= 1'b1;
					switch_rx[i].token <= rx_tok[i];
					// Static links bypass route lookup entirely.
					switch_rx[i].static_fwd <= static_en[i] && link_en[i];
					switch_rx[i].chanend <= static_chan[i];
				end
			end
		end
	end

	// Sticky error flags; a new error beats the clear-on-read.
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			link_err <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < elc_pkg::NUM_LINKS; i++)
			begin
				if (rx_illegal[i] || (rx_tok_valid[i] && switch_rx[i].valid
					&& !switch_rx_ready[i]))
				begin
					link_err[i] <= 1'b1;
				end
				else if (rd_cfg && slot == 3'(i) && err_seen[i])
				begin
					link_err[i] <= 1'b0;
				end
			end
		end
	end

	// Per-link serialiser and deserialiser.
	for (genvar g = 0; g < elc_pkg::NUM_LINKS; g++)
	begin : g_link
		elc_link_tx u_tx (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.enable(link_en[g]),
			.cfg(tx_cfg[g]),
			.tok_valid(tx_valid[g]),
			.tok(tx_token[g]),
			.tok_ready(tx_ready[g]),
			.wires(link_tx_wire[g])
		);
		elc_link_rx u_rx (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.enable(link_en[g]),
			.five_wire(five_wire[g]),
			.restart(rx_restart[g]),
			.wires_sync(rx_sync[g]),
			.tok_valid(rx_tok_valid[g]),
			.tok(rx_tok[g]),
			.illegal(rx_illegal[g])
		);
	end

endmodule // elc_link_control

/* test/elc_link_control_assertions.sv */
`timescale 1ns/100ps
// Watches the register port, pin handover and the lines of link zero.
module elc_link_control_assertions (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] pin_mux_to_link,
	input wire logic [7:0][4:0] link_tx_wire,
	input wire elc_pkg::elc_rx_t [7:0] switch_rx,
	input wire logic [7:0] switch_rx_ready
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Decode of the two register banks, eight aligned words each.
	wire logic is_cfg = paddr[11:5] == 7'h10 && paddr[1:0] == 2'h0;
	wire logic is_st = paddr[11:5] == 7'h14 && paddr[1:0] == 2'h0;
	// A read setup into one bank followed by its access cycle.
	sequence s_rd(logic bank);
		psel && !penable && !pwrite && bank ##1 penable;
	endsequence
	// Two idle cycles of link zero; one is not enough as the enable is registered.
	sequence s_off;
		!pin_mux_to_link[0] [*2];
	endsequence
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	property p_slverr;
		psel && penable |-> pslverr == !(is_cfg || is_st);
	endproperty
	property p_mux;
		psel && penable && pwrite && is_cfg
			|=> pin_mux_to_link[$past(paddr[4:2])] == $past(pwdata[31]);
	endproperty
	property p_cfg_rd;
		s_rd(is_cfg) |-> prdata[29:28] == 2'h0 && prdata[24:22] == 3'h0;
	endproperty
	property p_st_rd;
		s_rd(is_st) |-> prdata[30:5] == 26'h0;
	endproperty
	property p_gate;
		switch_rx[0].valid && switch_rx[0].static_fwd |-> pin_mux_to_link[0];
	endproperty
	// Writes are excluded, although disabling the link leaves the held token in place.
	property p_hold;
		switch_rx[0].valid && !switch_rx_ready[0] && !(psel && pwrite) |=> $stable(switch_rx[0]);
	endproperty
	property p_one;
		$onehot0(link_tx_wire[0] ^ $past(link_tx_wire[0])) && $stable(link_tx_wire[0][4]);
	endproperty
	property p_idle;
		s_off |-> $stable(link_tx_wire[0]);
	endproperty
	a_ready: assert property (p_ready) else $error("access not ready");
	a_slverr: assert property (p_slverr) else $error("slave error decode wrong");
	a_mux: assert property (p_mux) else $error("pin handover wrong");
	a_cfg_rd: assert property (p_cfg_rd) else $error("config read field wrong");
	a_st_rd: assert property (p_st_rd) else $error("static read field wrong");
	a_gate: assert property (p_gate) else $error("static flag on idle link");
	a_hold: assert property (p_hold) else $error("held token changed");
	a_one: assert property (p_one) else $error("bad line toggle");
	a_idle: assert property (p_idle) else $error("disabled link moved");
endmodule // elc_link_control_assertions

bind elc_link_control elc_link_control_assertions u_elc_link_control_assertions (
	.ref_clk(ref_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pin_mux_to_link(pin_mux_to_link),
	.link_tx_wire(link_tx_wire), .switch_rx(switch_rx), .switch_rx_ready(switch_rx_ready)
);

/* test/elc_remote_node.sv */
`timescale 1ns/100ps
// Far-end switch on one link, two-wire form only; sends queued tokens.
module elc_remote_node (
	input wire logic ref_clk,
	input wire logic slow,
	input wire logic send,
	input wire elc_pkg::elc_token_t send_tok,
	input wire logic bad,
	input wire logic [4:0] tx_wire,
	output logic [4:0] rx_wire,
	output logic got,
	output elc_pkg::elc_token_t got_tok,
	output logic busy
);
	// Tokens waiting to go to the device.
	elc_pkg::elc_token_t q[$];
	// Previous line levels and the partly received token.
	logic [4:0] prev = 5'h00;
	logic [9:0] sh = 10'h000;
	int cnt = 0;
	// Decodes the device's toggles, ten symbols LSB first.
	always @(posedge ref_clk)
	begin
		logic nb;
		nb = tx_wire[1] ^ prev[1];
		got <= 1'b0;
		prev <= tx_wire;
		if (send)
			q.push_back(send_tok);
		if ((tx_wire[1:0] ^ prev[1:0]) != 2'h0)
		begin
			sh <= {nb, sh[9:1]};
			cnt <= (cnt == 9) ? 0 : cnt + 1;
			if (cnt == 9)
			begin
				got <= 1'b1;
				got_tok <= {nb, sh[9:2]};
				// A greeting is answered with credit.
				if (nb && sh[9:2] == elc_pkg::GREETING_DATA)
					q.push_back({1'b1, elc_pkg::CREDIT_DATA});
			end
		end
	end
	// Sends one token at a time; the slow pace stretches the symbol spacing.
	initial
	begin
		logic [9:0] bits;
		rx_wire = 5'h00;
		busy = 1'b0;
		forever
		begin
			@(posedge ref_clk);
			if (bad)
				rx_wire[3:2] <= ~rx_wire[3:2];
			else if (q.size() > 0)
			begin
				bits = {q.pop_front(), 1'b0};
				busy <= 1'b1;
				for (int i = 0; i < 10; i++)
				begin
					rx_wire[bits[i]] <= ~rx_wire[bits[i]];
					repeat (slow ? 3 : 1) @(posedge ref_clk);
				end
				busy <= 1'b0;
			end
		end
	end
endmodule // elc_remote_node

/* test/elc_link_control_tb.sv */
`timescale 1ns/100ps
// Drives the register port and link zero's far end; a monitor checks results.
module elc_link_control_tb;
	localparam logic [31:0] EN = 32'h8000_0000;
	localparam logic [31:0] WIDE = 32'h4000_0000;
	localparam logic [31:0] ERR = 32'h0800_0000;
	localparam logic [31:0] CROUT = 32'h0400_0000;
	localparam logic [31:0] CRIN = 32'h0200_0000;
	localparam logic [31:0] INIT = 32'h0100_0000;
	localparam logic [31:0] RXRST = 32'h0080_0000;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic ref_clk = 1'b0;
	logic reset_n;
	logic [11:0] paddr;
	logic psel, penable, pwrite;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr;
	logic [7:0] pin_mux_to_link;
	logic [7:0][4:0] link_tx_wire, link_rx_wire;
	logic [7:0] user_tx_valid, user_tx_ready, switch_rx_ready;
	elc_pkg::elc_token_t [7:0] user_tx_token;
	elc_pkg::elc_rx_t [7:0] switch_rx;
	// Far-end controls and observations.
	logic slow, send, bad, got, busy;
	logic [4:0] rem_rx;
	elc_pkg::elc_token_t send_tok, got_tok, t;
	// Expected results: {mask, value} for reads, tokens for both directions.
	logic [63:0] rdq[$];
	elc_pkg::elc_rx_t rxq[$];
	elc_pkg::elc_token_t tokq[$];
	int fail_count = 0;
	int total_checks = 0;
	logic [31:0] cfgv;
	logic [4:0] ch;
	always #25 ref_clk = ~ref_clk;
	// Only link zero has a far end; the other receivers stay quiet.
	assign link_rx_wire = {35'h0, rem_rx};
	elc_link_control u_elc_link_control (.ref_clk(ref_clk), .reset_n(reset_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_mux_to_link(pin_mux_to_link), .link_tx_wire(link_tx_wire),
		.link_rx_wire(link_rx_wire), .user_tx_valid(user_tx_valid),
		.user_tx_token(user_tx_token), .user_tx_ready(user_tx_ready),
		.switch_rx(switch_rx), .switch_rx_ready(switch_rx_ready));
	elc_remote_node u_elc_remote_node (.ref_clk(ref_clk), .slow(slow), .send(send),
		.send_tok(send_tok), .bad(bad), .tx_wire(link_tx_wire[0]), .rx_wire(rem_rx),
		.got(got), .got_tok(got_tok), .busy(busy));
	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// A result with no note waiting counts as a mismatch.
	task chk(input logic [31:0] g, input logic [31:0] e, input logic ok);
		total_checks++;
		if (!ok || g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task cmp_rd(input logic [31:0] g);
		logic [63:0] n;
		n = (rdq.size() > 0) ? rdq.pop_front() : 64'h0;
		chk(g & n[63:32], n[31:0], n[63:32] != 32'h0);
	endtask
	task cmp_rx(input elc_pkg::elc_rx_t g);
		chk(32'(g), (rxq.size() > 0) ? 32'(rxq.pop_front()) : ~32'(g), 1'b1);
	endtask
	task cmp_tok(input elc_pkg::elc_token_t g);
		chk(32'(g), (tokq.size() > 0) ? 32'(tokq.pop_front()) : ~32'(g), 1'b1);
	endtask
	// Results are taken at the edge where each handshake completes.
	always @(posedge ref_clk)
	begin
		if (psel && penable && pready && !pwrite)
			cmp_rd(prdata);
		if (switch_rx[0].valid && switch_rx_ready[0])
			cmp_rx(switch_rx[0]);
		if (got)
			cmp_tok(got_tok);
	end
	// APB master; the request stands until pready is seen high.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		rdq.push_back({m, e});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// Waits for the far end and then the receive synchroniser to go quiet.
	task settle;
		while (tokq.size() > 0)
			@(posedge ref_clk);
		repeat (3) @(posedge ref_clk);
		while (busy === 1'b1)
			@(posedge ref_clk);
		repeat (6) @(posedge ref_clk);
	endtask
	task rsend(input elc_pkg::elc_token_t k);
		@(posedge ref_clk);
		send <= 1'b1;
		send_tok <= k;
		@(posedge ref_clk);
		send <= 1'b0;
		settle();
	endtask
	task done(input string n);
		$display("test %s finished", n);
	endtask
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		print_verdict();
	end
	initial
	begin
		{reset_n, psel, penable, pwrite, send, bad, slow} = 7'h00;
		{paddr, pwdata, user_tx_valid, user_tx_token} = '0;
		switch_rx_ready = 8'hFF;
		void'($urandom(55250));
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			rd(elc_pkg::CFG_BASE_ADDR + 12'(4 * i), 32'h0, ALL);
			rd(elc_pkg::STATIC_BASE_ADDR + 12'(4 * i), 32'h0, ALL);
		end
		rd(12'h300, 32'h0, ALL);
		done("reset");
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, elc_pkg::CFG_BASE_ADDR + 12'(4 * i), EN | WIDE);
			rd(elc_pkg::CFG_BASE_ADDR + 12'(4 * i), EN | WIDE, ALL);
			apb(1'b1, elc_pkg::CFG_BASE_ADDR + 12'(4 * i), 32'h0);
		end
		done("enable");
		cfgv = EN | (32'($urandom % 4) << 11) | 32'($urandom % 4);
		slow <= 1'($urandom);
		apb(1'b1, elc_pkg::CFG_BASE_ADDR, cfgv);
		rd(elc_pkg::CFG_BASE_ADDR, cfgv, ALL);
		tokq.push_back({1'b1, elc_pkg::GREETING_DATA});
		apb(1'b1, elc_pkg::CFG_BASE_ADDR, cfgv | INIT);
		settle();
		rd(elc_pkg::CFG_BASE_ADDR, cfgv | CRIN, ALL);
		tokq.push_back({1'b1, elc_pkg::CREDIT_DATA});
		rsend({1'b1, elc_pkg::GREETING_DATA});
		rd(elc_pkg::CFG_BASE_ADDR, cfgv | CRIN | CROUT, ALL);
		t = {1'b0, 8'($urandom)};
		tokq.push_back(t);
		@(posedge ref_clk);
		user_tx_valid <= 8'h01;
		user_tx_token[0] <= t;
		@(posedge ref_clk);
		while (user_tx_ready[0] !== 1'b1)
			@(posedge ref_clk);
		user_tx_valid <= 8'h00;
		settle();
		done("credit");
		@(posedge ref_clk);
		bad <= 1'b1;
		@(posedge ref_clk);
		bad <= 1'b0;
		settle();
		rd(elc_pkg::CFG_BASE_ADDR, ERR, ERR);
		rd(elc_pkg::CFG_BASE_ADDR, 32'h0, ERR);
		apb(1'b1, elc_pkg::CFG_BASE_ADDR, cfgv | RXRST);
		rd(elc_pkg::CFG_BASE_ADDR, cfgv | CRIN, ALL);
		done("error");
		for (int s = 0; s < 2; s++)
		begin
			ch = 5'($urandom);
			apb(1'b1, elc_pkg::STATIC_BASE_ADDR, {s[0], 26'h0, ch});
			rd(elc_pkg::STATIC_BASE_ADDR, {s[0], 26'h0, ch}, ALL);
			t = {1'b0, 8'($urandom)};
			rxq.push_back({1'b1, s[0], ch, t});
			switch_rx_ready[0] <= 1'b0;
			rsend(t);
			repeat ($urandom % 8) @(posedge ref_clk);
			switch_rx_ready[0] <= 1'b1;
			repeat (2) @(posedge ref_clk);
		end
		done("static");
		apb(1'b1, elc_pkg::CFG_BASE_ADDR, 32'h0);
		rsend({1'b0, 8'($urandom)});
		rd(elc_pkg::CFG_BASE_ADDR, 32'h0, ALL);
		done("disable");
		print_verdict();
	end
endmodule // elc_link_control_tb
